// >>> rtl/rcs_top.sv
// Summary of operation
// - Six reset kinds are told apart.
// - Some registers are never reset.
// - Most registers reload, but not on wake-up.
// - Pin path rejects short low pulses.
// - Power-up timer after POR, then oscillator timer in crystal modes.
// - RC mode, timer off: no delay.
// - Timeouts ignore pin; late release runs at once.
// - Power control register with two flags.
// - Brown-out flag cleared by brown-out reset.
// - Brown-out flag meaningless when detection off.
// - Power-on flag cleared only on power-on or by a software write of 0.
// - Delay lengths per oscillator mode.
// - Power-on sets timeout and power-down flags.
// - Flag updates per watchdog and pin event.
`timescale 1ns/100ps
`include "rcs_cfg.svh"

module rcs_top import rcs_pkg::*; #(
   parameter int unsigned POWERUP_TIMER_CYCLES = `RCS_POWERUP_TIMER_CYC
) (
   input  wire logic                   core_clk,
   input  wire logic                   resetn,
   input  wire logic                   ext_reset_pin_n,
   input  wire logic                   brownout_det,
   input  wire logic                   watchdog_timeout,
   input  wire logic                   sleep_mode,
   input  wire logic                   osc_tick,
   input  rcs_osc_t                    osc_mode,
   input  wire logic                   powerup_timer_off_cfg,
   input  wire logic                   brownout_enable_cfg,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`RCS_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   output logic                        core_reset_n,
   output logic                        reg_load,
   output logic                        wake_resume,
   output logic                        timeout_flag,
   output logic                        powerdown_flag,
   output logic                        irq
);
   // ----------------------------------------------------------------
   // Reset release and input synchronisers.
   // ----------------------------------------------------------------
   logic                    rst1_reg;
   logic                    rst_n;
   logic                    b1_reg;
   logic                    b2_reg;
   logic                    b3_reg;
   logic                    bor_lvl_reg;
   logic                    bor_q_reg;
   logic                    pin_q_reg;
   logic                    por_pend_reg;
   logic                    pin_low;
   rcs_seq_t                state_reg;
   rcs_seq_t                state_next;
   logic                    pend_reg;
   logic                    pend_next;
   logic                    tmr_start;
   logic [`RCS_TMR_W-1:0]   tmr_len;
   logic                    tmr_tick_sel;
   logic                    core_rst_n_reg;
   logic                    reg_load_reg;
   logic                    wake_reg;
   logic                    to_reg;
   logic                    pd_reg;
   logic                    por_flag_reg;
   logic                    bor_flag_reg;
   logic [`RCS_CAUSE_W-1:0] cause_reg;
   logic [`RCS_CAUSE_W-1:0] mask_reg;
   logic [`RCS_CAUSE_W-1:0] cause_set;
   logic [31:0]             prdata_reg;
   logic                    irq_reg;

   // Resetn is released through two stages so every flop on rst_n leaves reset
   // on the same edge.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         {rst1_reg, rst_n} <= 2'h0;
      end else begin
         {rst1_reg, rst_n} <= {1'b1, rst1_reg};
      end
   end

   // The supply monitor is asynchronous; its level moves on agreement.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {b1_reg, b2_reg, b3_reg} <= 3'h0;
         bor_lvl_reg <= 1'b0;
      end else begin
         {b1_reg, b2_reg, b3_reg} <= {brownout_det, b1_reg, b2_reg};
         bor_lvl_reg <= (b2_reg == b3_reg) ? b3_reg : bor_lvl_reg;
      end
   end

   rcs_pin_filter u_pin (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_n    (ext_reset_pin_n),
      .low_det  (pin_low)
   );

   // ----------------------------------------------------------------
   // Reset event decode.
   // ----------------------------------------------------------------
   // detection gated by enable.
   wire bor_act  = bor_lvl_reg & brownout_enable_cfg;
   wire bor_evt  = bor_act & ~bor_q_reg;
   wire pin_evt  = pin_low & ~pin_q_reg & ~bor_evt;
   wire por_evt  = por_pend_reg;
   wire wdt_ok   = watchdog_timeout & (state_reg == st_run) &
                   ~bor_evt & ~pin_evt;
   wire pin_run_evt  = pin_evt & ~sleep_mode;
   wire pin_slp_evt  = pin_evt & sleep_mode;
   wire wdt_rst_evt  = wdt_ok & ~sleep_mode;
   wire wdt_wake_evt = wdt_ok & sleep_mode;
   wire rst_evt      = por_evt | bor_evt | pin_evt | wdt_rst_evt;

   assign cause_set[`RCS_C_POR]      = por_evt;
   assign cause_set[`RCS_C_PIN_RUN]  = pin_run_evt;
   assign cause_set[`RCS_C_PIN_SLP]  = pin_slp_evt;
   assign cause_set[`RCS_C_WDT_RST]  = wdt_rst_evt;
   assign cause_set[`RCS_C_WDT_WAKE] = wdt_wake_evt;
   assign cause_set[`RCS_C_BOR]      = bor_evt;

   // Edge memories; the power-on event fires once after release.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bor_q_reg    <= 1'b0;
         pin_q_reg    <= 1'b0;
         por_pend_reg <= 1'b1;
      end else begin
         bor_q_reg    <= bor_act;
         pin_q_reg    <= pin_low;
         por_pend_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Timeout sequencer.
   // ----------------------------------------------------------------
   rcs_tmr_if tif ();

   rcs_timer u_tmr (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tif      (tif)
   );

   wire crystal  = (osc_mode == osc_lp) | (osc_mode == osc_xt) |
                   (osc_mode == osc_hs);
   wire internal_osc_mode   = (osc_mode == osc_int);
   wire powerup_timer_on  = ~powerup_timer_off_cfg;
   wire in_core  = (state_reg == st_run) | (state_reg == st_wake);

   wire [`RCS_TMR_W-1:0] powerup_timer_len = (`RCS_TMR_W)'(POWERUP_TIMER_CYCLES);
   wire [`RCS_TMR_W-1:0] ost_len  = (`RCS_TMR_W)'(`RCS_OST_TICKS);
   wire [`RCS_TMR_W-1:0] int_len  = (`RCS_TMR_W)'(`RCS_WAKE_INT_CYC);

   assign tif.start    = tmr_start;
   assign tif.len      = tmr_len;
   assign tif.use_tick = tmr_tick_sel;
   assign tif.tick     = osc_tick;

   // timers run whatever the pin does.
   always_comb begin
      state_next   = state_reg;
      pend_next    = pend_reg;
      tmr_start    = 1'b0;
      tmr_len      = '0;
      tmr_tick_sel = 1'b0;
      if (por_evt | bor_evt) begin
         state_next = st_hold;
         pend_next  = 1'b1;
      end else if ((pin_evt | wdt_rst_evt) & in_core) begin
         state_next = st_hold;
      end else begin
         case (state_reg)
            st_hold: begin
               if (pend_reg & ~bor_act) begin
                  pend_next = 1'b0;
                  if (powerup_timer_on) begin
                     tmr_start  = 1'b1;
                     tmr_len    = powerup_timer_len;
                     state_next = st_powerup_timer;
                  end else if (crystal) begin
                     tmr_start    = 1'b1;
                     tmr_len      = ost_len;
                     tmr_tick_sel = 1'b1;
                     state_next   = st_ost;
                  end
               end else if (~pend_reg & ~pin_low & ~bor_act) begin
                  state_next = st_run;
               end
            end
            st_powerup_timer: begin
               if (tif.done & crystal) begin
                  tmr_start    = 1'b1;
                  tmr_len      = ost_len;
                  tmr_tick_sel = 1'b1;
                  state_next   = st_ost;
               end else if (tif.done) begin
                  state_next = st_hold;
               end
            end
            st_ost: begin
               if (tif.done) begin
                  state_next = st_hold;
               end
            end
            st_run: begin
               if (wdt_wake_evt & crystal) begin
                  tmr_start    = 1'b1;
                  tmr_len      = ost_len;
                  tmr_tick_sel = 1'b1;
                  state_next   = st_wake;
               end else if (wdt_wake_evt & internal_osc_mode) begin
                  tmr_start  = 1'b1;
                  tmr_len    = int_len;
                  state_next = st_wake;
               end
            end
            st_wake: begin
               if (tif.done) begin
                  state_next = st_run;
               end
            end
            default: begin
               state_next = st_hold;
            end
         endcase
      end
   end

   wire core_rst_n_next = (state_next == st_run) |
                          (state_next == st_wake);
   wire wake_next = ((state_reg == st_wake) & tif.done & ~rst_evt) |
                    (wdt_wake_evt & ~crystal & ~internal_osc_mode);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= st_hold;
         pend_reg       <= 1'b1;
         core_rst_n_reg <= 1'b0;
         reg_load_reg   <= 1'b1;
         wake_reg       <= 1'b0;
      end else begin
         state_reg      <= state_next;
         pend_reg       <= pend_next;
         core_rst_n_reg <= core_rst_n_next;
         reg_load_reg   <= rst_evt;
         wake_reg       <= wake_next;
      end
   end

   // ----------------------------------------------------------------
   // Reset cause flags.
   // ----------------------------------------------------------------
   wire [`RCS_IDX_W-1:0] idx = paddr[`RCS_IDX_W+1:2];
   wire setup   = psel & ~penable;
   wire access  = psel & penable;
   wire hit_pc  = (idx == `RCS_IDX_POWER_CONTROL_STATUS);
   wire hit_ca  = (idx == `RCS_IDX_CAUSE);
   wire hit_mk  = (idx == `RCS_IDX_MASK);
   wire hit_fl  = (idx == `RCS_IDX_FLAGS);
   wire hit     = hit_pc | hit_ca | hit_mk | hit_fl;
   wire wr      = access & pwrite;
   wire power_control_status_wr = wr & hit_pc;
   wire cause_wr = wr & hit_ca;
   wire mask_wr  = wr & hit_mk;

   wire to_next = (wdt_rst_evt | wdt_wake_evt) ? 1'b0 :
                  (por_evt | pin_slp_evt)      ? 1'b1 : to_reg;
   wire pd_next = (wdt_wake_evt | pin_slp_evt) ? 1'b0 :
                  por_evt                      ? 1'b1 : pd_reg;
   wire por_next = por_evt ? 1'b0 :
                   power_control_status_wr ? pwdata[`RCS_POWER_CONTROL_STATUS_POR] : por_flag_reg;
   wire bor_next = bor_evt ? 1'b0 :
                   power_control_status_wr ? pwdata[`RCS_POWER_CONTROL_STATUS_BOR] : bor_flag_reg;
   // New events win over a write-one-to-clear in the same cycle.
   wire [`RCS_CAUSE_W-1:0] cause_clr =
      cause_wr ? pwdata[`RCS_CAUSE_W-1:0] : '0;
   wire [`RCS_CAUSE_W-1:0] cause_next = (cause_reg & ~cause_clr) |
                                        cause_set;
   wire [`RCS_CAUSE_W-1:0] mask_next =
      mask_wr ? pwdata[`RCS_CAUSE_W-1:0] : mask_reg;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         to_reg       <= 1'b1;
         pd_reg       <= 1'b1;
         por_flag_reg <= 1'b0;
         cause_reg    <= '0;
         mask_reg     <= '0;
         irq_reg      <= 1'b0;
      end else begin
         to_reg       <= to_next;
         pd_reg       <= pd_next;
         por_flag_reg <= por_next;
         cause_reg    <= cause_next;
         mask_reg     <= mask_next;
         irq_reg      <= |(cause_next & mask_next);
      end
   end

   always_ff @(posedge core_clk) begin
      bor_flag_reg <= bor_next;
   end

   // ----------------------------------------------------------------
   // APB read path; data is captured in setup for a zero-wait access.
   // ----------------------------------------------------------------
   wire [31:0] power_control_status_rd  = (32'(por_flag_reg) << `RCS_POWER_CONTROL_STATUS_POR) |
                          (32'(bor_flag_reg) << `RCS_POWER_CONTROL_STATUS_BOR);
   wire [31:0] flags_rd = (32'(to_reg) << `RCS_FLAG_TO) |
                          (32'(pd_reg) << `RCS_FLAG_PD);
   wire [31:0] rd_mux   = hit_pc ? power_control_status_rd :
                          hit_ca ? 32'(cause_reg) :
                          hit_mk ? 32'(mask_reg) :
                          hit_fl ? flags_rd : 32'h0000_0000;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_reg <= 32'h0000_0000;
      end else if (setup & ~pwrite) begin
         prdata_reg <= rd_mux;
      end
   end

   assign prdata         = prdata_reg;
   assign pready         = 1'b1;
   assign pslverr        = access & ~hit;
   assign core_reset_n   = core_rst_n_reg;
   assign reg_load       = reg_load_reg;
   assign wake_resume    = wake_reg;
   assign timeout_flag   = to_reg;
   assign powerdown_flag = pd_reg;
   assign irq            = irq_reg;

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   a_por_flags : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n) |-> to_reg && pd_reg && !por_flag_reg)
      else $error("Power-on flags wrong after release.");

   a_bor_clear : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      bor_evt |=> !bor_flag_reg)
      else $error("Brown-out flag not cleared.");

   a_wdt_reset_flags : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      wdt_rst_evt |=> !to_reg && pd_reg == $past(pd_reg))
      else $error("Watchdog reset flags wrong.");

   a_wdt_wake_flags : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      wdt_wake_evt |=> !to_reg && !pd_reg && !reg_load_reg)
      else $error("Watchdog wake-up flags or reload wrong.");

   a_pin_sleep_flags : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      pin_slp_evt |=> to_reg && !pd_reg && reg_load_reg)
      else $error("Pin reset in sleep flags wrong.");

   a_por_flag_hold : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !power_control_status_wr && !por_evt |=> $stable(por_flag_reg))
      else $error("Power-on flag changed without cause.");

   a_rc_no_delay : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      state_reg == st_hold && pend_reg && !bor_act && !powerup_timer_on &&
      !crystal && !rst_evt |=> state_reg == st_hold && !tif.busy)
      else $error("Delay applied with timers disabled.");

   a_powerup_timer_then_ost : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      state_reg == st_powerup_timer && tif.done && crystal && !rst_evt
      |=> state_reg == st_ost && tif.busy)
      else $error("Oscillator timer did not follow.");

   a_core_release : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(core_rst_n_reg) |-> $past(state_reg == st_hold &&
      !pend_reg && !pin_low && !bor_act))
      else $error("Core released before sources and delays ended.");
endmodule

// >>> rtl/rcs_cfg.svh
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH

// ----------------------------------------------------------------
// Clock and timing figures.
// ----------------------------------------------------------------
`define RCS_CLK_MHZ        50
`define RCS_POWERUP_TIMER_MS        72
`define RCS_POWERUP_TIMER_CYC       (`RCS_POWERUP_TIMER_MS * 1000 * `RCS_CLK_MHZ)
`define RCS_WAKE_INT_US    6
`define RCS_WAKE_INT_CYC   (`RCS_WAKE_INT_US * `RCS_CLK_MHZ)
`define RCS_OST_TICKS      1024
`define RCS_PIN_MIN_NS     2000
`define RCS_PIN_MIN_CYC    ((`RCS_PIN_MIN_NS * `RCS_CLK_MHZ + 999) / 1000)
`define RCS_PIN_CNT_W      8
`define RCS_TMR_W          22

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------
`define RCS_ADDR_W         12
`define RCS_IDX_W          10
`define RCS_IDX_POWER_CONTROL_STATUS       10'h08e
`define RCS_IDX_CAUSE      10'h090
`define RCS_IDX_MASK       10'h091
`define RCS_IDX_FLAGS      10'h092

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define RCS_POWER_CONTROL_STATUS_BOR       0
`define RCS_POWER_CONTROL_STATUS_POR       1
`define RCS_FLAG_TO        0
`define RCS_FLAG_PD        1
`define RCS_CAUSE_W        6
`define RCS_C_POR          0
`define RCS_C_PIN_RUN      1
`define RCS_C_PIN_SLP      2
`define RCS_C_WDT_RST      3
`define RCS_C_WDT_WAKE     4
`define RCS_C_BOR          5

`endif

// >>> rtl/rcs_pkg.sv
package rcs_pkg;
   // Oscillator modes selected by the configuration word.
   typedef enum logic [2:0] {
      osc_lp, osc_xt, osc_hs, osc_ec, osc_int, osc_rc
   } rcs_osc_t;

   // Reset sequencer states.
   typedef enum logic [2:0] {
      st_hold, st_powerup_timer, st_ost, st_run, st_wake
   } rcs_seq_t;
endpackage

// >>> rtl/rcs_tmr_if.sv
`timescale 1ns/100ps
`include "rcs_cfg.svh"

// Control and status of the shared timeout counter.
interface rcs_tmr_if;
   logic                   start;
   logic [`RCS_TMR_W-1:0]  len;
   logic                   use_tick;
   logic                   tick;
   logic                   done;
   logic                   busy;
   modport ctl (output start, len, use_tick, tick, input done, busy);
   modport tmr (input start, len, use_tick, tick, output done, busy);
endinterface

// >>> rtl/rcs_timer.sv
`timescale 1ns/100ps
`include "rcs_cfg.svh"

module rcs_timer import rcs_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   rcs_tmr_if.tmr   tif
);
   logic [`RCS_TMR_W-1:0] cnt_reg;
   logic                  busy_reg;
   logic                  done_reg;
   logic                  sel_reg;

   // ----------------------------------------------------------------
   // Step and end decode.
   // ----------------------------------------------------------------
   // A step is a core cycle, or an oscillator tick when counting Tosc.
   wire step = busy_reg & (~sel_reg | tif.tick);
   wire last = step & (cnt_reg == (`RCS_TMR_W)'(1));

   assign tif.done = done_reg;
   assign tif.busy = busy_reg;

   // A new start reloads the count even while busy, restarting the wait.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg  <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         sel_reg  <= 1'b0;
      end else if (tif.start) begin
         cnt_reg  <= tif.len;
         busy_reg <= 1'b1;
         done_reg <= 1'b0;
         sel_reg  <= tif.use_tick;
      end else begin
         done_reg <= last;
         if (last) begin
            busy_reg <= 1'b0;
         end
         if (step) begin
            cnt_reg <= cnt_reg - (`RCS_TMR_W)'(1);
         end
      end
   end
endmodule

// >>> rtl/rcs_pin_filter.sv
`timescale 1ns/100ps
`include "rcs_cfg.svh"

module rcs_pin_filter (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic pin_n,
   output logic      low_det
);
   logic                     s1_reg;
   logic                     s2_reg;
   logic                     s3_reg;
   logic                     level_reg;
   logic                     low_reg;
   logic [`RCS_PIN_CNT_W-1:0] cnt_reg;
   logic [`RCS_PIN_CNT_W-1:0] run_reg;

   // ----------------------------------------------------------------
   // Synchroniser and glitch filter.
   // ----------------------------------------------------------------
   // The level only moves once the second and third stages agree.
   wire level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
   wire full = (cnt_reg == (`RCS_PIN_CNT_W)'(`RCS_PIN_MIN_CYC - 1));

   assign low_det = low_reg;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {s1_reg, s2_reg, s3_reg} <= 3'h7;
         level_reg <= 1'b1;
         low_reg   <= 1'b0;
         cnt_reg   <= '0;
      end else begin
         {s1_reg, s2_reg, s3_reg} <= {pin_n, s1_reg, s2_reg};
         level_reg <= level_next;
         if (level_reg) begin
            cnt_reg <= '0;
            low_reg <= 1'b0;
         end else if (!full) begin
            cnt_reg <= cnt_reg + (`RCS_PIN_CNT_W)'(1);
         end else begin
            low_reg <= 1'b1;
         end
      end
   end

   // Count of stable low cycles, read only by the check below.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_reg <= '0;
      end else if (level_reg) begin
         run_reg <= '0;
      end else if (!(&run_reg)) begin
         run_reg <= run_reg + (`RCS_PIN_CNT_W)'(1);
      end
   end

   a_pin_min_width : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(low_reg) |-> run_reg == (`RCS_PIN_CNT_W)'(`RCS_PIN_MIN_CYC))
      else $error("Pin reset accepted at wrong low width.");
endmodule

// >>> tb/rcs_far_model.sv
`timescale 1ns/100ps
// Far side: reset pin driver, supply monitor and oscillator.
module rcs_far_model (
   input  wire logic core_clk,
   input  wire logic pin_req,
   input  wire logic bor_req,
   output logic      ext_reset_pin_n,
   output logic      brownout_det,
   output logic      osc_tick
);
   logic tick_reg = 1'h0;
   // Tosc is two core cycles, so a full start-up wait spans 2048 cycles.
   always_ff @(posedge core_clk) begin
      tick_reg <= ~tick_reg;
   end
   assign osc_tick        = tick_reg;
   assign ext_reset_pin_n = ~pin_req;
   assign brownout_det    = bor_req;
endmodule

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb import rcs_pkg::*; ;
   localparam logic [11:0] PCN = 12'h238, CAU = 12'h240;
   localparam logic [11:0] MSK = 12'h244, FLG = 12'h248;
   logic        core_clk = 1'h0, resetn = 1'h0, pin_req = 1'h0;
   logic        bor_req = 1'h0, watchdog_timeout = 1'h0, sleep_mode = 1'h0;
   logic        powerup_timer_off_cfg = 1'h0, brownout_enable_cfg = 1'h1;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, q, prdata;
   rcs_osc_t    osc_mode = osc_ec;
   logic        pready, pslverr, core_reset_n, reg_load, wake_resume, irq;
   logic        timeout_flag, powerdown_flag, ext_reset_pin_n;
   logic        brownout_det, osc_tick;
   int          fails = 0, num_checks = 0, cyc = 0, n;

   rcs_far_model far_u (.core_clk, .pin_req, .bor_req, .ext_reset_pin_n,
                        .brownout_det, .osc_tick);
   rcs_top #(.POWERUP_TIMER_CYCLES(150)) dut_u (.core_clk, .resetn, .ext_reset_pin_n,
      .brownout_det, .watchdog_timeout, .sleep_mode, .osc_tick, .osc_mode,
      .powerup_timer_off_cfg, .brownout_enable_cfg, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_reset_n,
      .reg_load, .wake_resume, .timeout_flag, .powerdown_flag, .irq);

   always #10 core_clk = ~core_clk;

   // A hang anywhere counts as a mismatch and still reaches the verdict.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude;
      end
   end

   task automatic conclude;
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; read data and error are taken at the ready edge.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      @(posedge core_clk);
      while (pready !== 1'h1) @(posedge core_clk);
      q = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0000_0000);
      chk(q, e);
   endtask

   task automatic step;
      @(posedge core_clk);
      #1;
   endtask

   task automatic wait_run;
      n = 0;
      while (core_reset_n !== 1'h1 && n < 9000) begin
         @(posedge core_clk);
         n++;
      end
      chk(core_reset_n, 1'h1);
   endtask

   task automatic wdt_pulse(input logic s);
      @(posedge core_clk);
      sleep_mode       <= s;
      watchdog_timeout <= 1'h1;
      @(posedge core_clk);
      watchdog_timeout <= 1'h0;
      #1;
   endtask

   task automatic pin_pulse(input logic s, input int len);
      @(posedge core_clk);
      sleep_mode <= s;
      pin_req    <= 1'h1;
      repeat (len) @(posedge core_clk);
      pin_req    <= 1'h0;
      wait_run;
   endtask

   task automatic brown(input int len);
      @(posedge core_clk);
      bor_req <= 1'h1;
      repeat (10) @(posedge core_clk);
      bor_req <= 1'h0;
      repeat (len) @(posedge core_clk);
      pin_req <= 1'h0;
      wait_run;
   endtask

   initial begin
      repeat (12) @(posedge core_clk);
      resetn <= 1'h1;
      wait_run;
      chk(n > 150, 1'h1);
      chk({timeout_flag, powerdown_flag}, 2'h3);
      apb(1'h0, PCN, 32'h0000_0000);
      chk(q[1], 1'h0);
      rd(CAU, 32'h0000_0001);
      // Software sets both flags after power-on.
      apb(1'h1, PCN, 32'h0000_0003);
      apb(1'h1, MSK, 32'h0000_003f);
      step;
      chk(irq, 1'h1);
      apb(1'h1, CAU, 32'h0000_0001);
      step;
      chk(irq, 1'h0);
      wdt_pulse(1'h0);
      chk({reg_load, core_reset_n}, 2'h2);
      wait_run;
      rd(FLG, 32'h0000_0002);
      rd(PCN, 32'h0000_0003);
      rd(CAU, 32'h0000_0008);
      apb(1'h1, CAU, 32'h0000_003f);
      wdt_pulse(1'h1);
      chk({reg_load, wake_resume}, 2'h1);
      rd(FLG, 32'h0000_0000);
      rd(CAU, 32'h0000_0010);
      apb(1'h1, CAU, 32'h0000_003f);
      pin_pulse(1'h1, 150);
      rd(FLG, 32'h0000_0001);
      rd(CAU, 32'h0000_0004);
      apb(1'h1, CAU, 32'h0000_003f);
      pin_pulse(1'h0, 50);
      rd(CAU, 32'h0000_0000);
      pin_pulse(1'h0, 150);
      rd(FLG, 32'h0000_0001);
      rd(CAU, 32'h0000_0002);
      // Unmapped read: error in access, no data.
      apb(1'h0, 12'h3fc, 32'h0000_0000);
      chk(err, 1'h1);
      chk(q, 32'h0000_0000);
      brown(0);
      chk(n > 150, 1'h1);
      rd(PCN, 32'h0000_0002);
      // The pin-run cause is still sticky from before.
      rd(CAU, 32'h0000_0022);
      // Pin held low past the timeouts: release starts at once.
      pin_req <= 1'h1;
      brown(300);
      chk(n < 20, 1'h1);
      osc_mode              <= osc_rc;
      powerup_timer_off_cfg <= 1'h1;
      brown(0);
      chk(n < 20, 1'h1);
      // Crystal with the timer on: 150 cycles, then 1024 ticks.
      osc_mode              <= osc_xt;
      powerup_timer_off_cfg <= 1'h0;
      brown(0);
      chk(n > 2190, 1'h1);
      wdt_pulse(1'h1);
      n = 0;
      while (wake_resume !== 1'h1 && n < 5000) begin
         step;
         n++;
      end
      chk(n > 2000 && n < 5000, 1'h1);
      conclude;
   end
endmodule
